//--- src/stepper_motion_command_core.sv
// stepper motion command core with AHB-Lite register slave
//
// Operation
// - encoder B leading A counts clockwise, A leading B counterclockwise.
// - encoder edges counted continuously, count readable anytime, even moving.
// - step rates 1 to 30000 sps at 1 sps resolution.
// - prescaler divides step rate range by 1 through 255.
// - current mode accepts E 1-30000, B 1-2000 (1-13000 with rtos off), S 0-200.
// - reset loads E 3000, B 300, S 10.
// - continuous motion starts ramping toward new speed at the next step after command.
// - signed 32-bit position always updated, read in full.
// - relative moves offset from position without disturbing the counter.
// - eight-deep move queue, next move starts within one step.
// - direction query answers minus toward home, plus toward limit.
// - continuous command with soft limits and zero slope gets range error.
// - E update in continuous ignored at zero slope, B==E, limit decel.
// - current mode ramps linearly between B and E, slope max 200.
// - software-selectable legacy mode reproduces old non-linear motion.
// - software switch selects real-time mode and which limits apply.
// - legacy value 46250 fastest, each decrement adds one timer tick.
// - legacy step period is (46379 minus value) timer ticks.
// - legacy prescale multiplies timer tick by prescale plus one.
// - 2000-character storage reachable by host commands.
// - absolute move goes toward limit if target above position, home if below.
`timescale 1ns/10ps
`default_nettype none
`include "stepper_cfg.svh"
module stepper_motion_command_core
  import stepper_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // encoder channels
  input wire logic encA,
  input wire logic encB,
  // motor drive
  output logic stepPulse,
  output logic stepDir,
  output logic moving
);
  // -----------------------------
  // state
  // -----------------------------
  core_s s_q;
  core_s s_d;
  logic [7:0] nvMem [`NV_SIZE];

  logic take;
  logic wr;
  logic [15:0] wv16;
  logic [7:0] wv8;
  logic [15:0] eMax;
  logic [15:0] bMin;
  logic [15:0] bMax;
  logic [7:0] sMin;
  logic [7:0] sMax;
  logic [8:0] presc;
  logic [16:0] legPeriod;
  logic [47:0] incr;
  logic [47:0] thr;
  logic [47:0] accSum;
  logic [16:0] rUp;
  logic [16:0] beginPlus;
  logic [16:0] endPlus;
  logic [15:0] rDown;
  logic [15:0] rDownE;
  logic [31:0] remN;
  logic [31:0] diff;
  logic push;
  logic pop;
  qentry_s newEntry;
  qentry_s e;
  cmd_e wkind;

  assign take = hsel && htrans[1] && hready;
  assign wr = s_q.wrPend;
  assign wv16 = hwdata[15:0];
  assign wv8 = hwdata[7:0];
  assign hreadyout = !s_q.rdPh1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign stepPulse = s_q.stepPulse;
  assign stepDir = s_q.dir;
  assign moving = (s_q.st == MOT_RUN);

  // -----------------------------
  // rate limits and timing terms
  // -----------------------------
  always_comb begin
    // legacy uses its old ranges, wider for E and B, narrower for S; rtos off relaxes begin velocity
    eMax = s_q.legacy ? `E_MAX_LEG : `E_MAX_NEW;
    bMin = s_q.legacy ? 16'h0000 : 16'h0001;
    bMax = s_q.legacy ? `B_MAX_LEG : (s_q.rtos ? `B_MAX_RTOS : `B_MAX_NORTOS);
    sMin = s_q.legacy ? 8'h01 : 8'h00;
    sMax = s_q.legacy ? `S_MAX_LEG : `S_MAX_NEW;
    if (s_q.legacy) begin
      presc = {1'b0, s_q.prescale} + 9'h001;
    end else begin
      presc = (s_q.prescale == 8'h00) ? 9'h001 : {1'b0, s_q.prescale};
    end
    legPeriod = `LEG_BASE_VAL - {1'b0, s_q.rate};
    // accumulator adds rate per cycle (cycle time in legacy) and steps on reaching the threshold
    if (s_q.legacy) begin
      incr = 48'(`CYCLE_TU);
      thr = 48'(legPeriod) * 48'(presc) * 48'(`LEG_TICK_TU);
    end else begin
      incr = {32'h0000_0000, s_q.rate};
      thr = 48'(`CLK_HZ) * 48'(presc);
    end
    accSum = s_q.acc + incr;
    rUp = {1'b0, s_q.rate} + {9'h000, s_q.slope};
    beginPlus = {1'b0, s_q.beginVel} + {9'h000, s_q.slope};
    endPlus = {1'b0, s_q.endVel} + {9'h000, s_q.slope};
    rDown = ({1'b0, s_q.rate} > beginPlus) ? 16'(s_q.rate - {8'h00, s_q.slope}) : s_q.beginVel;
    rDownE = ({1'b0, s_q.rate} > endPlus) ? 16'(s_q.rate - {8'h00, s_q.slope}) : s_q.endVel;
    remN = s_q.remaining - 32'h0000_0001;
  end

  // -----------------------------
  // next state
  // -----------------------------
  always_comb begin
    s_d = s_q;
    s_d.stepPulse = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    diff = 32'h0000_0000;
    e = s_q.q[s_q.head];
    wkind = cmd_e'(hwdata[2:0]);
    newEntry.kind = wkind;
    newEntry.arg = s_q.target;

    // bus phases: writes land in the data phase, reads wait one cycle
    s_d.wrPend = take && hwrite;
    s_d.rdPh2 = s_q.rdPh1;
    s_d.rdPh1 = take && !hwrite;
    if (take) begin
      s_d.addr = haddr[7:0];
    end

    // register writes
    if (wr) begin
      case (s_q.addr)
        `OFS_CTRL: begin
          s_d.legacy = hwdata[0];
          s_d.rtos = hwdata[1];
          s_d.softLim = hwdata[2];
        end
        `OFS_END_VEL: begin
          if (wv16 < 16'h0001 || wv16 > eMax) begin
            s_d.reply = `CHR_ERR;
          end else if (s_q.st == MOT_RUN && s_q.cont && (s_q.slope == 8'h00 ||
                       s_q.beginVel == s_q.endVel || s_q.trip)) begin
            s_d.endVel = s_q.endVel;
          end else begin
            s_d.endVel = wv16;
          end
        end
        `OFS_BEGIN_VEL: begin
          if (wv16 < bMin || wv16 > bMax) begin
            s_d.reply = `CHR_ERR;
          end else begin
            s_d.beginVel = wv16;
          end
        end
        `OFS_SLOPE: begin
          if (wv8 < sMin || wv8 > sMax) begin
            s_d.reply = `CHR_ERR;
          end else begin
            s_d.slope = wv8;
          end
        end
        `OFS_PRESCALE: s_d.prescale = wv8;
        `OFS_TARGET: s_d.target = hwdata;
        `OFS_LIMIT_POS: s_d.limitPos = hwdata;
        `OFS_NV_ADDR: s_d.nvAddr = (hwdata[10:0] > `NV_LAST) ? 11'h000 : hwdata[10:0];
        `OFS_NV_DATA: s_d.nvAddr = (s_q.nvAddr == `NV_LAST) ? 11'h000 : s_q.nvAddr + 11'h001;
        `OFS_CMD: begin
          case (wkind)
            CMD_STOP: begin
              if (s_q.st == MOT_RUN) begin
                s_d.decel = 1'b1;
              end
            end
            CMD_DIR: s_d.reply = s_q.lastDirLim ? `CHR_PLUS : `CHR_MINUS;
            CMD_ABS, CMD_REL, CMD_CONT_LIM, CMD_CONT_HOME: begin
              if (s_q.count == 4'(`QDEPTH)) begin
                s_d.reply = `CHR_ERR;
              end else if ((wkind == CMD_CONT_LIM || wkind == CMD_CONT_HOME) &&
                           s_q.softLim && s_q.slope == 8'h00) begin
                s_d.reply = `CHR_ERR;
              end else begin
                push = 1'b1;
              end
            end
            default: s_d.reply = s_q.reply;
          endcase
        end
        default: s_d.reply = s_q.reply;
      endcase
    end

    // read data captured once pending writes have landed
    if (s_q.rdPh1) begin
      case (s_q.addr)
        `OFS_CTRL: s_d.rdata = {29'h0, s_q.softLim, s_q.rtos, s_q.legacy};
        `OFS_END_VEL: s_d.rdata = {16'h0000, s_q.endVel};
        `OFS_BEGIN_VEL: s_d.rdata = {16'h0000, s_q.beginVel};
        `OFS_SLOPE: s_d.rdata = {24'h000000, s_q.slope};
        `OFS_PRESCALE: s_d.rdata = {24'h000000, s_q.prescale};
        `OFS_TARGET: s_d.rdata = s_q.target;
        `OFS_POSITION: s_d.rdata = s_q.pos;
        `OFS_ENC_COUNT: s_d.rdata = s_q.encCount;
        `OFS_STATUS: s_d.rdata = {16'h0000, s_q.count == 4'(`QDEPTH), s_q.dir, s_q.decel,
                                  s_q.count, s_q.st == MOT_RUN, s_q.reply};
        `OFS_LIMIT_POS: s_d.rdata = s_q.limitPos;
        `OFS_NV_ADDR: s_d.rdata = {21'h000000, s_q.nvAddr};
        `OFS_NV_DATA: begin
          s_d.rdata = {24'h000000, nvMem[s_q.nvAddr]};
          s_d.nvAddr = (s_q.nvAddr == `NV_LAST) ? 11'h000 : s_q.nvAddr + 11'h001;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // motion
    case (s_q.st)
      MOT_IDLE: begin
        if (s_q.count != 4'h0) begin
          pop = 1'b1;
          s_d.acc = 48'h0;
          s_d.accelSteps = 32'h0000_0000;
          s_d.decel = 1'b0;
          s_d.trip = 1'b0;
          s_d.cont = 1'b0;
          s_d.rate = (s_q.slope == 8'h00) ? s_q.endVel : s_q.beginVel;
          case (e.kind)
            CMD_ABS: diff = e.arg - s_q.pos;
            CMD_REL: diff = e.arg;
            default: diff = 32'h0000_0000;
          endcase
          if (e.kind == CMD_CONT_LIM || e.kind == CMD_CONT_HOME) begin
            s_d.cont = 1'b1;
            s_d.dir = (e.kind == CMD_CONT_LIM);
            s_d.lastDirLim = (e.kind == CMD_CONT_LIM);
            s_d.st = MOT_RUN;
          end else if (diff != 32'h0000_0000) begin
            s_d.dir = !diff[31];
            s_d.lastDirLim = !diff[31];
            s_d.remaining = diff[31] ? 32'(-diff) : diff;
            s_d.st = MOT_RUN;
          end
        end
      end
      MOT_RUN: begin
        // soft limit trip turns continuous motion into a controlled stop
        if (s_q.cont && s_q.softLim && !s_q.decel &&
            ((s_q.dir && $signed(s_q.pos) >= $signed(s_q.limitPos)) ||
             (!s_q.dir && $signed(s_q.pos) <= 0))) begin
          s_d.decel = 1'b1;
          s_d.trip = 1'b1;
        end
        if (accSum >= thr) begin
          s_d.acc = accSum - thr;
          s_d.stepPulse = 1'b1;
          s_d.pos = s_q.dir ? s_q.pos + 32'h0000_0001 : s_q.pos - 32'h0000_0001;
          s_d.remaining = remN;
          if ((!s_q.cont && remN == 32'h0000_0000) ||
              (s_q.decel && (s_q.slope == 8'h00 || s_q.rate <= s_q.beginVel))) begin
            s_d.st = MOT_IDLE;
            s_d.cont = 1'b0;
            s_d.decel = 1'b0;
          end else if (s_q.decel || (!s_q.cont && remN <= s_q.accelSteps)) begin
            s_d.rate = rDown;
          end else if (s_q.slope == 8'h00) begin
            s_d.rate = s_q.endVel;
          end else if (s_q.rate < s_q.endVel) begin
            s_d.rate = (rUp > {1'b0, s_q.endVel}) ? s_q.endVel : rUp[15:0];
            s_d.accelSteps = s_q.accelSteps + 32'h0000_0001;
          end else if (s_q.rate > s_q.endVel) begin
            s_d.rate = rDownE;
          end
        end else begin
          s_d.acc = accSum;
        end
      end
      default: s_d.st = MOT_IDLE;
    endcase

    // queue pointers
    if (push) begin
      s_d.q[s_q.tail] = newEntry;
      s_d.tail = s_q.tail + 3'h1;
    end
    if (pop) begin
      s_d.head = s_q.head + 3'h1;
    end
    s_d.count = s_q.count + (push ? 4'h1 : 4'h0) - (pop ? 4'h1 : 4'h0);

    // quadrature: every edge on either channel counts
    s_d.encA = encA;
    s_d.encB = encB;
    case ({s_q.encA, s_q.encB, encA, encB})
      4'h1, 4'h7, 4'hE, 4'h8: s_d.encCount = s_q.encCount + 32'h0000_0001;
      4'h2, 4'hB, 4'hD, 4'h4: s_d.encCount = s_q.encCount - 32'h0000_0001;
      default: s_d.encCount = s_q.encCount;
    endcase
  end

  // -----------------------------
  // registers
  // -----------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.endVel <= `RST_END;
      s_q.beginVel <= `RST_BEGIN;
      s_q.slope <= `RST_SLOPE;
      s_q.rtos <= 1'b1;
      s_q.st <= MOT_IDLE;
      s_q.lastDirLim <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // storage is not cleared by reset, as a nonvolatile store would keep it
  always_ff @(posedge clock) begin
    if (!reset && wr && s_q.addr == `OFS_NV_DATA) begin
      nvMem[s_q.nvAddr] <= wv8;
    end
  end
endmodule
`default_nettype wire

//--- shared/stepper_cfg.svh
// constants of the stepper motion command core
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH
// -----------------------------
// timing
// -----------------------------
`define CLK_PERIOD_NS 10
`define CLK_HZ (1000000000 / `CLK_PERIOD_NS)
`define TU_PER_NS 10000
`define CYCLE_TU (`CLK_PERIOD_NS * `TU_PER_NS)
`define LEG_TICK_TU 5425347
`define LEG_BASE_VAL 17'h0B52B
// -----------------------------
// register byte offsets
// -----------------------------
`define OFS_CTRL 8'h00
`define OFS_END_VEL 8'h04
`define OFS_BEGIN_VEL 8'h08
`define OFS_SLOPE 8'h0C
`define OFS_PRESCALE 8'h10
`define OFS_TARGET 8'h14
`define OFS_CMD 8'h18
`define OFS_POSITION 8'h1C
`define OFS_ENC_COUNT 8'h20
`define OFS_STATUS 8'h24
`define OFS_LIMIT_POS 8'h28
`define OFS_NV_ADDR 8'h2C
`define OFS_NV_DATA 8'h30
// -----------------------------
// reset values and limits
// -----------------------------
`define RST_END 16'h0BB8
`define RST_BEGIN 16'h012C
`define RST_SLOPE 8'h0A
`define E_MAX_NEW 16'h7530
`define B_MAX_RTOS 16'h07D0
`define B_MAX_NORTOS 16'h32C8
`define S_MAX_NEW 8'hC8
`define E_MAX_LEG 16'hB4AA
`define B_MAX_LEG 16'hB3B0
`define S_MAX_LEG 8'h64
// -----------------------------
// reply characters and sizes
// -----------------------------
`define CHR_ERR 8'h21
`define CHR_PLUS 8'h2B
`define CHR_MINUS 8'h2D
`define NV_SIZE 2000
`define NV_LAST 11'h7CF
`define QDEPTH 8
`endif

//--- shared/stepper_pkg.sv
// types of the stepper motion command core
`include "stepper_cfg.svh"
package stepper_pkg;
  typedef enum logic [0:0] {MOT_IDLE = 1'b0, MOT_RUN = 1'b1} motion_e;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_ABS = 3'b001, CMD_REL = 3'b010, CMD_CONT_LIM = 3'b011,
    CMD_CONT_HOME = 3'b100, CMD_STOP = 3'b101, CMD_DIR = 3'b110, CMD_RSV = 3'b111
  } cmd_e;
  typedef struct packed {
    cmd_e kind;
    logic [31:0] arg;
  } qentry_s;
  typedef struct packed {
    logic wrPend;
    logic rdPh1;
    logic rdPh2;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic legacy;
    logic rtos;
    logic softLim;
    logic [15:0] endVel;
    logic [15:0] beginVel;
    logic [7:0] slope;
    logic [7:0] prescale;
    logic [31:0] target;
    logic [31:0] limitPos;
    logic [10:0] nvAddr;
    logic [7:0] reply;
    qentry_s [`QDEPTH-1:0] q;
    logic [2:0] head;
    logic [2:0] tail;
    logic [3:0] count;
    motion_e st;
    logic [15:0] rate;
    logic [31:0] remaining;
    logic [31:0] accelSteps;
    logic decel;
    logic trip;
    logic cont;
    logic dir;
    logic [47:0] acc;
    logic [31:0] pos;
    logic lastDirLim;
    logic stepPulse;
    logic encA;
    logic encB;
    logic [31:0] encCount;
  } core_s;
endpackage

//--- test/stepper_core_props.sv
// port assertions for the motion command core
`timescale 1ns/10ps
`default_nettype none
module stepper_core_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // motor
  input wire logic stepPulse,
  input wire logic stepDir,
  input wire logic moving
);
  // 30000 sps is 3333.3 cycles; margin for accumulator carry
  localparam int MinGap = 3300;
  logic [15:0] gap_q;
  logic take;
  assign take = hsel & htrans[1] & hready;
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_q <= 16'hFFFF;
    end else if (stepPulse) begin
      gap_q <= 16'h0;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_read_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
  property p_write_zero;
    take && hwrite |=> hreadyout;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write stalled");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus error response");
  property p_pulse;
    stepPulse |=> !stepPulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("step pulse too long");
  property p_step_moving;
    stepPulse |-> $past(moving);
  endproperty
  a_step_moving: assert property (p_step_moving) else $error("step while idle");
  property p_gap;
    stepPulse |-> gap_q >= MinGap;
  endproperty
  a_gap: assert property (p_gap) else $error("steps too close");
  property p_dir_hold;
    stepPulse |-> $stable(stepDir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved on step");
  property p_rdata_hold;
    $changed(hrdata) |-> $past(hreadyout) == 1'b0;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_quiet;
    disable iff (1'b0) reset |=> !stepPulse && !moving && hreadyout;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy in reset");
endmodule
bind stepper_motion_command_core stepper_core_props props (.clock(clock), .reset(reset),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .stepPulse(stepPulse), .stepDir(stepDir), .moving(moving));
`default_nettype wire

//--- test/host_model.sv
// bus host and encoder source facing the motion core
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clock,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // encoder
  output logic encA,
  output logic encB
);
  logic [1:0] ph;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    encA = 1'b0;
    encB = 1'b0;
    ph = 2'h0;
  end
  // called just after an edge, so transfers run back to back
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock);
    while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock);
    while (hready !== 1'b1);
    q = hrdata;
    // stale data never looks valid
    hwdata <= ~d;
  endtask
  // gray walk: clockwise has b leading a
  task automatic turn(input int n, input logic cw);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      ph = cw ? ph + 2'h1 : ph - 2'h1;
      encA <= ph[1];
      encB <= ph[1] ^ ph[0];
    end
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the motion command core
`timescale 1ns/10ps
`default_nettype none
`include "stepper_cfg.svh"
module testbench;
  logic clock;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic encA;
  logic encB;
  logic stepPulse;
  logic stepDir;
  logic moving;
  logic [31:0] rd;
  int num_errors;
  int tests_run;
  int cycles;
  int steps;
  int period;
  int lastPulse;
  stepper_motion_command_core DUT (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .encA(encA), .encB(encB),
    .stepPulse(stepPulse), .stepDir(stepDir), .moving(moving));
  host_model host (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .encA(encA),
    .encB(encB));
  always #5 clock = ~clock;
  // about 60000 cycles of steps plus bus traffic
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (stepPulse) begin
      steps <= steps + 1;
      period <= cycles - lastPulse;
      lastPulse <= cycles;
    end
    if (cycles == 90000) begin
      num_errors++;
      final_report();
    end
  end
  // -----------------------------
  // tasks
  // -----------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd);
    check($sformatf("offset %h", a), rd, exp);
  endtask
  task automatic lim(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    w(a, d);
    r(a, exp);
  endtask
  task automatic reply(input logic [7:0] exp);
    host.xfer(1'b0, `OFS_STATUS, 32'h0, rd);
    check("reply", {24'h0, rd[7:0]}, {24'h0, exp});
  endtask
  task automatic settle();
    do host.xfer(1'b0, `OFS_STATUS, 32'h0, rd);
    while (rd[12:8] !== 5'h0);
  endtask
  task automatic move(input logic [2:0] kind, input logic [31:0] arg);
    w(`OFS_TARGET, arg);
    w(`OFS_CMD, {29'h0, kind});
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // -----------------------------
  // sequence
  // -----------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    cycles = 0;
    num_errors = 0;
    tests_run = 0;
    steps = 0;
    period = 0;
    lastPulse = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    r(`OFS_END_VEL, 32'h0BB8);
    r(`OFS_BEGIN_VEL, 32'h012C);
    r(`OFS_SLOPE, 32'h0A);
    r(`OFS_CTRL, 32'h2);
    r(`OFS_POSITION, 32'h0);
    r(8'h40, 32'h0);
    $display("test reset values done");
    lim(`OFS_END_VEL, 32'h7531, 32'h0BB8);
    reply(8'h21);
    lim(`OFS_END_VEL, 32'h7530, 32'h7530);
    lim(`OFS_END_VEL, 32'h0, 32'h7530);
    lim(`OFS_BEGIN_VEL, 32'h07D1, 32'h012C);
    lim(`OFS_BEGIN_VEL, 32'h07D0, 32'h07D0);
    lim(`OFS_SLOPE, 32'hC9, 32'h0A);
    lim(`OFS_SLOPE, 32'hC8, 32'hC8);
    lim(`OFS_SLOPE, 32'h0, 32'h0);
    $display("test limits done");
    move(3'h2, 32'h3);
    host.turn(6, 1'b1);
    r(`OFS_ENC_COUNT, 32'h6);
    host.turn(2, 1'b0);
    r(`OFS_ENC_COUNT, 32'h4);
    settle();
    r(`OFS_POSITION, 32'h3);
    w(`OFS_CMD, 32'h6);
    reply(8'h2B);
    move(3'h1, 32'h1);
    move(3'h2, 32'h2);
    settle();
    r(`OFS_POSITION, 32'h3);
    move(3'h1, 32'h0);
    settle();
    w(`OFS_CMD, 32'h6);
    reply(8'h2D);
    check("direction", {31'h0, stepDir}, 32'h0);
    move(3'h2, 32'hFFFFFFFE);
    settle();
    r(`OFS_POSITION, 32'hFFFFFFFE);
    // slope zero keeps the speed fixed, so the update must be ignored
    move(3'h3, 32'h0);
    lim(`OFS_END_VEL, 32'h61A8, 32'h7530);
    w(`OFS_CMD, 32'h5);
    settle();
    r(`OFS_POSITION, 32'hFFFFFFFF);
    $display("test motion done");
    w(`OFS_CTRL, 32'h6);
    move(3'h3, 32'h0);
    reply(8'h21);
    check("moving", {31'h0, moving}, 32'h0);
    $display("test continuous refusal done");
    w(`OFS_END_VEL, 32'h61A8);
    w(`OFS_PRESCALE, 32'h2);
    move(3'h2, 32'h2);
    settle();
    check("step period", period, 32'(2 * `CLK_HZ / 25000));
    check("steps", steps, 32'hF);
    r(`OFS_POSITION, 32'h1);
    $display("test prescale done");
    w(`OFS_NV_ADDR, 32'h7CF);
    w(`OFS_NV_DATA, 32'h5A);
    w(`OFS_NV_DATA, 32'hA5);
    r(`OFS_NV_ADDR, 32'h1);
    // second reset: settings return, storage keeps its bytes
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    r(`OFS_END_VEL, 32'h0BB8);
    w(`OFS_NV_ADDR, 32'h7CF);
    r(`OFS_NV_DATA, 32'h5A);
    r(`OFS_NV_DATA, 32'hA5);
    w(`OFS_CTRL, 32'h0);
    lim(`OFS_BEGIN_VEL, 32'h32C8, 32'h32C8);
    w(`OFS_CTRL, 32'h1);
    lim(`OFS_END_VEL, 32'hB4AA, 32'hB4AA);
    lim(`OFS_SLOPE, 32'h0, 32'h0A);
    $display("test reset and modes done");
    final_report();
  end
endmodule
`default_nettype wire
